// ==== inc/acc_pkg.sv ====
// Purpose: shared constants and types for the converter control block
// Assumes: 8-bit special function register bus, one clock
// Notes: addresses are the byte addresses of the register bus
package acc_pkg;
  // ==========================================================================
  // register addresses
  localparam logic [7:0] ACC_ADDR_CTRL = 8'hC5;
  localparam logic [7:0] ACC_ADDR_RES_HI = 8'hC3;
  localparam logic [7:0] ACC_ADDR_RES_LO = 8'hC2;
  // ==========================================================================
  // control register layout
  localparam int ACC_BIT_DONE = 7;
  localparam int ACC_BIT_CONT = 6;
  localparam int ACC_BIT_IE = 5;
  localparam int ACC_BIT_OVR = 4;
  localparam int ACC_SEL_W = 4;
  localparam logic [7:0] ACC_CTRL_RESET = 8'h00;
  localparam logic [7:0] ACC_RDATA_IDLE = 8'h00;
  // ==========================================================================
  // result layout: sign in the top bit, then magnitude bits 10..0
  localparam int ACC_RES_W = 12;
  localparam logic [3:0] ACC_LO_PAD = 4'h0;
  // ==========================================================================
  // input select codes and timing
  localparam logic [3:0] ACC_SEL_DIFF_BASE = 4'h8;
  localparam logic [3:0] ACC_SEL_REF = 4'hC;
  localparam int ACC_CONV_CYCLES = 224;
  // ==========================================================================
  // converter sequencer state
  typedef enum logic {
    ACC_ST_IDLE = 1'b0,
    ACC_ST_CONV = 1'b1
  } acc_state_e;
endpackage

// ==== hdl/acc_input_mux.sv ====
// Purpose: decode the input select code into converter input routing
// Assumes: purely combinational, registered by the caller
// Notes: codes above the reference code route nothing
`timescale 1ns/1ps
module acc_input_mux
  import acc_pkg::*;
(
  input wire logic [3:0] sel, // input select code
  output logic [2:0] pos_ch, // channel on the positive input
  output logic [2:0] neg_ch, // channel on the negative input
  output logic neg_common, // negative input on the floating common
  output logic ref_pair, // reference pair routed to the converter
  output logic sel_valid // code selects a defined input
);
  // ==========================================================================
  // routing decode
  // default path parks everything on channel 0 with no valid routing
  always_comb begin
    pos_ch = 3'h0;
    neg_ch = 3'h0;
    neg_common = 1'b0;
    ref_pair = 1'b0;
    sel_valid = 1'b0;
    if (sel < ACC_SEL_DIFF_BASE) begin
      pos_ch = sel[2:0];
      neg_common = 1'b1;
      sel_valid = 1'b1;
    end else if (sel < ACC_SEL_REF) begin
      pos_ch = {sel[1:0], 1'b1};
      neg_ch = {sel[1:0], 1'b0};
      sel_valid = 1'b1;
    end else if (sel == ACC_SEL_REF) begin
      ref_pair = 1'b1;
      sel_valid = 1'b1;
    end
  end
endmodule

// ==== hdl/acc_top.sv ====
// Purpose: conversion control for the 12-bit converter behind the register bus
// Assumes: converter result is valid on ADC_RESULT when the conversion ends, same clock
// Notes: a write to control while idle starts one conversion
// How it works
// - codes 0..7 route channel n positive, floating common negative
// - codes 8..11 route differential pairs 1/0, 3/2, 5/4, 7/6
// - done flag sets at the end of every conversion, result stored
// - reading the high result byte clears done and overrun
// - continuous enable runs back-to-back conversions of 224 cycles each
// - clearing continuous lets the running conversion finish, then stops
// - conversion ending while done is set sets overrun and overwrites result
// - control register at C5H: done, continuous, irq enable, overrun, select
// - high byte at C3H: sign, then result bits 10..4
// - low byte at C2H: result bits 3..0 high, zeros below
// - control write with irq enable gives interrupt 3 after 224 cycles
`timescale 1ns/1ps
module acc_top
  import acc_pkg::*;
#(
  parameter int CONV_CYCLES = ACC_CONV_CYCLES // clock cycles per conversion
) (
  input wire logic MCLK, // system clock
  input wire logic SYS_RST, // asynchronous reset, active high
  input wire logic [7:0] SFR_ADDR, // register address
  input wire logic [7:0] SFR_WDATA, // write data
  input wire logic SFR_WR, // write strobe
  input wire logic SFR_RD, // read strobe
  output logic [7:0] SFR_RDATA, // read data, one cycle after the strobe
  input wire logic [ACC_RES_W-1:0] ADC_RESULT, // converter result, sign on top
  output logic CONV_START, // start pulse to the converter core
  output logic [2:0] POS_CH, // positive input channel
  output logic [2:0] NEG_CH, // negative input channel
  output logic NEG_COMMON, // negative input on floating common
  output logic REF_PAIR, // reference pair selected
  output logic SEL_VALID, // selection is defined
  output logic INT3_REQ // interrupt 3 request pulse
);
  localparam int CNT_W = $clog2(CONV_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);

  // ==========================================================================
  // bus decode
  logic wr_ctrl;
  logic rd_hi;
  logic rd_lo;
  logic rd_ctrl;
  assign wr_ctrl = SFR_WR && (SFR_ADDR == ACC_ADDR_CTRL);
  assign rd_hi = SFR_RD && (SFR_ADDR == ACC_ADDR_RES_HI);
  assign rd_lo = SFR_RD && (SFR_ADDR == ACC_ADDR_RES_LO);
  assign rd_ctrl = SFR_RD && (SFR_ADDR == ACC_ADDR_CTRL);

  // ==========================================================================
  // sequencer
  acc_state_e state_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic conv_end;
  logic start_now;
  logic cont_reg;
  logic ie_reg;
  logic done_reg;
  logic ovr_reg;
  logic [ACC_SEL_W-1:0] sel_reg;
  logic [ACC_RES_W-1:0] res_reg;

  assign conv_end = (state_reg == ACC_ST_CONV) && (cnt_reg == CNT_LAST);
  // a write while busy changes settings but never restarts the conversion
  assign start_now = wr_ctrl && (state_reg == ACC_ST_IDLE);

  // state and cycle counter
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      state_reg <= ACC_ST_IDLE;
      cnt_reg <= '0;
    end else begin
      unique case (state_reg)
        ACC_ST_IDLE: begin
          cnt_reg <= '0;
          if (start_now) begin
            state_reg <= ACC_ST_CONV;
          end
        end
        ACC_ST_CONV: begin
          if (conv_end) begin
            cnt_reg <= '0;
            // continuous bit only checked at the end, so clearing it never cuts a conversion short
            if (!cont_reg) begin
              state_reg <= ACC_ST_IDLE;
            end
          end else begin
            cnt_reg <= cnt_reg + 1'b1;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // control register writable fields
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cont_reg <= ACC_CTRL_RESET[ACC_BIT_CONT];
      ie_reg <= ACC_CTRL_RESET[ACC_BIT_IE];
      sel_reg <= ACC_CTRL_RESET[ACC_SEL_W-1:0];
    end else if (wr_ctrl) begin
      cont_reg <= SFR_WDATA[ACC_BIT_CONT];
      ie_reg <= SFR_WDATA[ACC_BIT_IE];
      sel_reg <= SFR_WDATA[ACC_SEL_W-1:0];
    end
  end

  // status flags: a conversion end in the same cycle as the clearing read wins
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      done_reg <= ACC_CTRL_RESET[ACC_BIT_DONE];
      ovr_reg <= ACC_CTRL_RESET[ACC_BIT_OVR];
    end else if (conv_end) begin
      done_reg <= 1'b1;
      if (done_reg) begin
        ovr_reg <= 1'b1;
      end else if (rd_hi) begin
        ovr_reg <= 1'b0;
      end
    end else if (rd_hi) begin
      done_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end
  end

  // result capture, always overwrites the previous one
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      res_reg <= '0;
    end else if (conv_end) begin
      res_reg <= ADC_RESULT;
    end
  end

  // ==========================================================================
  // read data, idle value when nothing mapped is read
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      SFR_RDATA <= ACC_RDATA_IDLE;
    end else if (rd_ctrl) begin
      SFR_RDATA <= {done_reg, cont_reg, ie_reg, ovr_reg, sel_reg};
    end else if (rd_hi) begin
      SFR_RDATA <= res_reg[ACC_RES_W-1:4];
    end else if (rd_lo) begin
      SFR_RDATA <= {res_reg[3:0], ACC_LO_PAD};
    end else begin
      SFR_RDATA <= ACC_RDATA_IDLE;
    end
  end

  // ==========================================================================
  // interrupt and converter start pulses
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      INT3_REQ <= 1'b0;
      CONV_START <= 1'b0;
    end else begin
      INT3_REQ <= conv_end && ie_reg;
      CONV_START <= start_now || (conv_end && cont_reg);
    end
  end

  // ==========================================================================
  // input routing, registered so the pins never glitch
  logic [2:0] mux_pos;
  logic [2:0] mux_neg;
  logic mux_common;
  logic mux_ref;
  logic mux_valid;
  acc_input_mux u_mux (
    .sel(sel_reg),
    .pos_ch(mux_pos),
    .neg_ch(mux_neg),
    .neg_common(mux_common),
    .ref_pair(mux_ref),
    .sel_valid(mux_valid)
  );

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      POS_CH <= 3'h0;
      NEG_CH <= 3'h0;
      NEG_COMMON <= 1'b0;
      REF_PAIR <= 1'b0;
      SEL_VALID <= 1'b0;
    end else begin
      POS_CH <= mux_pos;
      NEG_CH <= mux_neg;
      NEG_COMMON <= mux_common;
      REF_PAIR <= mux_ref;
      SEL_VALID <= mux_valid;
    end
  end

  // ==========================================================================
  // checks
  property p_irq_after_start;
    @(posedge MCLK) disable iff (SYS_RST)
      (start_now && SFR_WDATA[ACC_BIT_IE]) |-> ##225 INT3_REQ;
  endproperty
  a_irq_after_start: assert property (p_irq_after_start) else $error("no interrupt 224 cycles after start");

  property p_single;
    @(posedge MCLK) disable iff (SYS_RST)
      (sel_reg < ACC_SEL_DIFF_BASE) |=> (POS_CH == $past(sel_reg[2:0])) && NEG_COMMON;
  endproperty
  a_single: assert property (p_single) else $error("single-ended routing wrong");

  property p_diff;
    @(posedge MCLK) disable iff (SYS_RST)
      (sel_reg >= ACC_SEL_DIFF_BASE && sel_reg < ACC_SEL_REF) |=>
        (POS_CH == NEG_CH + 3'h1) && !NEG_COMMON && !NEG_CH[0] && (NEG_CH[2:1] == $past(sel_reg[1:0]));
  endproperty
  a_diff: assert property (p_diff) else $error("differential routing wrong");

  property p_ref;
    @(posedge MCLK) disable iff (SYS_RST)
      (sel_reg == ACC_SEL_REF) |=> REF_PAIR && SEL_VALID && !NEG_COMMON;
  endproperty
  a_ref: assert property (p_ref) else $error("reference routing wrong");

  property p_read_clears;
    @(posedge MCLK) disable iff (SYS_RST)
      (rd_hi && !conv_end) |=> !done_reg && !ovr_reg;
  endproperty
  a_read_clears: assert property (p_read_clears) else $error("high byte read did not clear flags");

  property p_overrun;
    @(posedge MCLK) disable iff (SYS_RST)
      (conv_end && done_reg) |=> ovr_reg && done_reg && (res_reg == $past(ADC_RESULT));
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun not flagged");

  property p_cont_period;
    @(posedge MCLK) disable iff (SYS_RST)
      (conv_end && cont_reg) |=> CONV_START ##223 conv_end;
  endproperty
  a_cont_period: assert property (p_cont_period) else $error("continuous period wrong");

  property p_stop;
    @(posedge MCLK) disable iff (SYS_RST)
      (state_reg == ACC_ST_CONV && !conv_end) |=> (state_reg == ACC_ST_CONV);
  endproperty
  a_stop: assert property (p_stop) else $error("conversion cut short");

  property p_irq;
    @(posedge MCLK) disable iff (SYS_RST)
      (conv_end && ie_reg) |=> INT3_REQ ##1 !INT3_REQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt pulse wrong");

  property p_done;
    @(posedge MCLK) disable iff (SYS_RST)
      conv_end |=> done_reg;
  endproperty
  a_done: assert property (p_done) else $error("done flag not set");

  property p_ctrl_read;
    @(posedge MCLK) disable iff (SYS_RST)
      rd_ctrl |=> SFR_RDATA == {$past(done_reg), $past(cont_reg), $past(ie_reg), $past(ovr_reg), $past(sel_reg)};
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback wrong");

  property p_lo_read;
    @(posedge MCLK) disable iff (SYS_RST)
      rd_lo |=> (SFR_RDATA[3:0] == ACC_LO_PAD) && (SFR_RDATA[7:4] == $past(res_reg[3:0]));
  endproperty
  a_lo_read: assert property (p_lo_read) else $error("low byte layout wrong");

  property p_hi_read;
    @(posedge MCLK) disable iff (SYS_RST)
      rd_hi |=> SFR_RDATA == $past(res_reg[ACC_RES_W-1:4]);
  endproperty
  a_hi_read: assert property (p_hi_read) else $error("high byte layout wrong");
endmodule

// ==== bench/acc_top_tb.sv ====
// Purpose: self-checking bench for the converter control block
// Assumes: register bus strobes driven on falling edges, full 224-cycle conversions
// Notes: the bench keeps its own copy of control fields and the stored result
`timescale 1ns/1ps
module acc_top_tb
  import acc_pkg::*;
;
  logic MCLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [7:0] SFR_ADDR = 8'h00;
  logic [7:0] SFR_WDATA = 8'h00;
  logic SFR_WR = 1'b0;
  logic SFR_RD = 1'b0;
  logic [7:0] SFR_RDATA;
  logic [ACC_RES_W-1:0] ADC_RESULT = 12'h000;
  logic CONV_START;
  logic [2:0] POS_CH;
  logic [2:0] NEG_CH;
  logic NEG_COMMON;
  logic REF_PAIR;
  logic SEL_VALID;
  logic INT3_REQ;
  int n_errors = 0;
  int compares = 0;
  logic [11:0] res_q;
  logic [3:0] sel;
  int n;
  int pulses;

  // ==========================================================================
  // clock and device
  always #5 MCLK = ~MCLK;

  acc_top i_dut (.MCLK(MCLK), .SYS_RST(SYS_RST), .SFR_ADDR(SFR_ADDR), .SFR_WDATA(SFR_WDATA),
    .SFR_WR(SFR_WR), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA), .ADC_RESULT(ADC_RESULT),
    .CONV_START(CONV_START), .POS_CH(POS_CH), .NEG_CH(NEG_CH), .NEG_COMMON(NEG_COMMON),
    .REF_PAIR(REF_PAIR), .SEL_VALID(SEL_VALID), .INT3_REQ(INT3_REQ));

  // ==========================================================================
  // shared helpers
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one-cycle strobe, released on the next falling edge
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    @(negedge MCLK);
    SFR_WR = 1'b1;
    SFR_ADDR = addr;
    SFR_WDATA = data;
    @(negedge MCLK);
    SFR_WR = 1'b0;
  endtask

  // read data stands for the cycle after the strobe edge only
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge MCLK);
    SFR_RD = 1'b1;
    SFR_ADDR = addr;
    @(negedge MCLK);
    SFR_RD = 1'b0;
    chk({4'h0, SFR_RDATA}, {4'h0, exp});
  endtask

  // counts falling edges until the interrupt pulse, bounded
  task automatic wait_int(input int start, output int cnt);
    cnt = start;
    do begin
      @(negedge MCLK);
      cnt++;
    end while (INT3_REQ !== 1'b1 && cnt < 400);
  endtask

  // expected routing as {pos, neg, common, ref, valid}
  function automatic logic [11:0] exp_route(input int c);
    if (c < 8)
      return {3'b000, 3'(c), 3'd0, 3'b101};
    else if (c < 12)
      return {3'b000, 3'(2 * (c - 8) + 1), 3'(2 * (c - 8)), 3'b001};
    else if (c == 12)
      return 12'h003;
    return 12'h000;
  endfunction

  task automatic give_verdict();
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================================
  // watchdog: the sequence needs under 3000 cycles
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end

  // ==========================================================================
  // main sequence
  initial begin
    void'($urandom(29));
    repeat (4) @(negedge MCLK);
    SYS_RST = 1'b0;
    rd(ACC_ADDR_CTRL, 8'h00);
    // every select code, checked on the routing outputs
    res_q = 12'($urandom());
    ADC_RESULT = res_q;
    for (int c = 0; c < 16; c++) begin
      wr(ACC_ADDR_CTRL, 8'(c));
      @(negedge MCLK);
      chk({3'b000, POS_CH, NEG_CH, NEG_COMMON, REF_PAIR, SEL_VALID}, exp_route(c));
    end
    repeat (230) @(negedge MCLK);
    rd(ACC_ADDR_RES_HI, res_q[11:4]);
    // single conversion with interrupt enabled
    sel = 4'($urandom_range(0, 12));
    res_q = 12'($urandom());
    ADC_RESULT = res_q;
    wr(ACC_ADDR_CTRL, {4'h2, sel});
    wait_int(0, n);
    chk(12'(n), 12'd224);
    rd(ACC_ADDR_CTRL, {4'hA, sel});
    rd(ACC_ADDR_RES_LO, {res_q[3:0], 4'h0});
    rd(ACC_ADDR_RES_HI, res_q[11:4]);
    rd(ACC_ADDR_CTRL, {4'h2, sel});
    // continuous run: two results, the second overruns the first
    wr(ACC_ADDR_CTRL, {4'h6, sel});
    wait_int(0, n);
    chk(12'(n), 12'd224);
    chk({11'h000, CONV_START}, 12'h001);
    res_q = 12'($urandom());
    ADC_RESULT = res_q;
    wait_int(0, n);
    chk(12'(n), 12'd224);
    rd(ACC_ADDR_CTRL, {4'hF, sel});
    rd(ACC_ADDR_RES_LO, {res_q[3:0], 4'h0});
    rd(ACC_ADDR_RES_HI, res_q[11:4]);
    rd(ACC_ADDR_CTRL, {4'h6, sel});
    // clearing continuous lets the running conversion finish, then stops
    wr(ACC_ADDR_CTRL, {4'h2, sel});
    wait_int(0, n);
    chk({11'h000, INT3_REQ}, 12'h001);
    chk({11'h000, CONV_START}, 12'h000);
    pulses = 0;
    repeat (300) begin
      @(negedge MCLK);
      pulses += int'(INT3_REQ === 1'b1 || CONV_START === 1'b1);
    end
    chk(12'(pulses), 12'h000);
    // last continuous result, read to clear done before the next start
    rd(ACC_ADDR_RES_HI, res_q[11:4]);
    // read-only bits and result registers refuse writes
    res_q = 12'($urandom());
    ADC_RESULT = res_q;
    wr(ACC_ADDR_CTRL, {4'h9, sel});
    rd(ACC_ADDR_CTRL, {4'h0, sel});
    wr(ACC_ADDR_RES_HI, 8'hFF);
    wr(ACC_ADDR_RES_LO, 8'hFF);
    // interrupt enable is off, so this conversion must stay silent
    pulses = 0;
    repeat (230) begin
      @(negedge MCLK);
      pulses += int'(INT3_REQ === 1'b1);
    end
    chk(12'(pulses), 12'h000);
    rd(ACC_ADDR_RES_LO, {res_q[3:0], 4'h0});
    rd(8'hC4, ACC_RDATA_IDLE);
    rd(ACC_ADDR_CTRL, {4'h8, sel});
    rd(ACC_ADDR_RES_HI, res_q[11:4]);
    rd(ACC_ADDR_CTRL, {4'h0, sel});
    // reset in mid-run ends continuous conversions
    wr(ACC_ADDR_CTRL, {4'h6, sel});
    repeat (100) @(negedge MCLK);
    SYS_RST = 1'b1;
    repeat (4) @(negedge MCLK);
    SYS_RST = 1'b0;
    @(negedge MCLK);
    chk({3'b000, POS_CH, NEG_CH, NEG_COMMON, REF_PAIR, SEL_VALID}, exp_route(0));
    pulses = 0;
    repeat (300) begin
      @(negedge MCLK);
      pulses += int'(INT3_REQ === 1'b1 || CONV_START === 1'b1);
    end
    chk(12'(pulses), 12'h000);
    rd(ACC_ADDR_CTRL, 8'h00);
    rd(ACC_ADDR_RES_HI, 8'h00);
    give_verdict();
  end
endmodule
